// ---- hw/umx_map.svh ----
// register offsets, field positions, reset values and bus codes of the modem pin block
`ifndef UMX_MAP_SVH
`define UMX_MAP_SVH

// register indices; the byte address on the register bus is four times the index
`define UMX_IDX_MCR 2'h0
`define UMX_IDX_MSR 2'h1
`define UMX_IDX_ISR 2'h2
`define UMX_IDX_IMR 2'h3

// byte offsets on the register bus
`define UMX_OFF_MCR 8'h00
`define UMX_OFF_MSR 8'h04
`define UMX_OFF_ISR 8'h08
`define UMX_OFF_IMR 8'h0c

// modem status field positions
`define UMX_MSR_RING_BIT 6
`define UMX_MSR_FLAG_BIT 2

// interrupt status and mask field positions
`define UMX_INT_RING_BIT 0

// reset values
`define UMX_MCR_RST 8'h00
`define UMX_ISR_RST 8'h00
`define UMX_IMR_RST 8'h00

// register bus responses
`define UMX_RESP_OKAY 2'h0
`define UMX_RESP_SLVERR 2'h2

`endif

// ---- hw/umx_pkg.sv ----
// types shared by the modem pin block
package umx_pkg;

  // modem control register layout, msb first
  typedef struct packed {
    logic [1:0] spare;
    logic auto_rts;
    logic loop;
    logic out_b;
    logic out_a;
    logic rts;
    logic dtr;
  } umx_mcr_t;

  // parallel host bus pins, as seen at the package edge
  typedef struct packed {
    logic select_high_a;
    logic select_high_b;
    logic select_low_n;
    logic read_strobe_low_active_n;
    logic read_strobe_high_active;
    logic [2:0] addr;
  } umx_pbus_t;

endpackage

// ---- hw/umx_top.sv ----
// modem control pins, ring capture, host read strobes and register bus slave
`timescale 1ns/10ps
`include "umx_map.svh"

// What this block does
// - setting a user-output control bit drives its pin low.
// - user pins sit high when their bit is clear, at reset, in loop mode.
// - a selected device answers a read on either strobe polarity.
// - modem status bit 6 shows the present ring-indicate level.
// - ring low-to-high sets modem status bit 2 until the status is read.
// - an enabled ring low-to-high raises the interrupt output.
// - setting the request-to-send bit drives that pin active.
// - request-to-send sits high at reset, in loop mode, or bit clear.
// - auto mode lets the receive threshold force request-to-send inactive.
// - master reset clears the registers and forces pins to reset levels.
module umx_top import umx_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic master_reset_input,
  input wire logic ring_indicate,
  input wire logic receiver_clock,
  input wire umx_pbus_t host_bus,
  input wire logic rx_threshold_hit,
  output logic [7:0] host_data_o,
  output logic host_data_oe,
  output logic user_output_a_n,
  output logic user_output_b_n,
  output logic request_to_send_n,
  output logic loop_mode,
  output logic rx_sample_tick,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // pin synchronisers
  logic mr_s1, mr_s2;
  logic ring_s1, ring_s2, ring_d;
  logic rck_s1, rck_s2, rck_d;
  umx_pbus_t pb_s1, pb_s2;
  logic pin_rd_d;
  // declared early: the strobe delay flop reads it ahead of its decode
  logic pin_rd_act;

  // registers
  umx_mcr_t mcr_r;
  logic ring_flag_r;
  logic [7:0] isr_r;
  logic [7:0] imr_r;
  logic out_a_n_r, out_b_n_r, rts_n_r, tick_r;
  logic [7:0] host_data_r;

  // register bus state
  logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [7:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;

  function automatic logic addr_hit(input logic [7:0] addr);
    addr_hit = (addr[7:4] == 4'h0) && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic [7:0] read_word(input logic [1:0] idx, input umx_mcr_t modem_control_register,
                                           input logic ring, input logic flag,
                                           input logic [7:0] isr, input logic [7:0] imr);
    logic [7:0] msr;
    msr = 8'h00;
    msr[`UMX_MSR_RING_BIT] = ring;
    msr[`UMX_MSR_FLAG_BIT] = flag;
    case (idx)
      `UMX_IDX_MCR: read_word = modem_control_register;
      `UMX_IDX_MSR: read_word = msr;
      `UMX_IDX_ISR: read_word = isr;
      `UMX_IDX_IMR: read_word = imr;
      default: read_word = 8'h00;
    endcase
  endfunction

  // master reset pin is asynchronous to aclk, so it is synchronised first
  wire all_rst = !aresetn || mr_s2;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mr_s1 <= 1'b0;
      mr_s2 <= 1'b0;
    end else begin
      mr_s1 <= master_reset_input;
      mr_s2 <= mr_s1;
    end
  end

  always_ff @(posedge aclk) begin
    if (all_rst) begin
      ring_s1 <= 1'b0;
      ring_s2 <= 1'b0;
      ring_d <= 1'b0;
      rck_s1 <= 1'b0;
      rck_s2 <= 1'b0;
      rck_d <= 1'b0;
      pb_s1 <= '0;
      pb_s2 <= '0;
      pin_rd_d <= 1'b0;
    end else begin
      ring_s1 <= ring_indicate;
      ring_s2 <= ring_s1;
      ring_d <= ring_s2;
      rck_s1 <= receiver_clock;
      rck_s2 <= rck_s1;
      rck_d <= rck_s2;
      pb_s1 <= host_bus;
      pb_s2 <= pb_s1;
      pin_rd_d <= pin_rd_act;
    end
  end

  // edge detectors look only at the second stage
  wire ring_edge = ring_s2 && !ring_d;
  // rclk must stay well below aclk/4 or edges are missed
  wire rck_edge = rck_s2 && !rck_d;

  // parallel host read path
  wire pin_sel = pb_s2.select_high_a && pb_s2.select_high_b && !pb_s2.select_low_n;
  wire pin_strobe = !pb_s2.read_strobe_low_active_n || pb_s2.read_strobe_high_active;
  assign pin_rd_act = pin_sel && pin_strobe;
  wire pin_rd_rise = pin_rd_act && !pin_rd_d;
  wire pin_idx_ok = !pb_s2.addr[2];
  wire [1:0] pin_idx = pb_s2.addr[1:0];
  wire pin_msr_rd = pin_rd_rise && pin_idx_ok && (pin_idx == `UMX_IDX_MSR);

  // register bus decode
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_hold_r && w_hold_r && !bvalid_r;
  wire wr_hit = addr_hit(aw_addr_r);
  wire wr_mcr = wr_go && w_strb_r && (aw_addr_r == `UMX_OFF_MCR);
  wire wr_isr = wr_go && w_strb_r && (aw_addr_r == `UMX_OFF_ISR);
  wire wr_imr = wr_go && w_strb_r && (aw_addr_r == `UMX_OFF_IMR);
  wire ar_go = s_axi_arvalid && s_axi_arready;
  wire rd_hit = addr_hit(s_axi_araddr);
  wire axi_msr_rd = ar_go && (s_axi_araddr == `UMX_OFF_MSR);
  wire msr_read = axi_msr_rd || pin_msr_rd;
  wire [7:0] axi_word = read_word(s_axi_araddr[3:2], mcr_r, ring_s2, ring_flag_r, isr_r, imr_r);
  wire [7:0] pin_word = pin_idx_ok ?
                        read_word(pin_idx, mcr_r, ring_s2, ring_flag_r, isr_r, imr_r) : 8'h00;

  // status bits: the set term wins over any clear in the same cycle
  wire [7:0] isr_set = {7'h00, ring_edge};
  wire [7:0] isr_clr = wr_isr ? w_data_r : 8'h00;
  wire [7:0] isr_nxt = (isr_r & ~isr_clr) | isr_set;
  wire ring_flag_nxt = ring_edge || (ring_flag_r && !msr_read);

  always_ff @(posedge aclk) begin
    if (all_rst) begin
      mcr_r <= `UMX_MCR_RST;
      imr_r <= `UMX_IMR_RST;
    end else begin
      if (wr_mcr) mcr_r <= w_data_r;
      if (wr_imr) imr_r <= w_data_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (all_rst) begin
      isr_r <= `UMX_ISR_RST;
      ring_flag_r <= 1'b0;
    end else begin
      isr_r <= isr_nxt;
      ring_flag_r <= ring_flag_nxt;
    end
  end

  // pins are registered so they never glitch on a decode change
  always_ff @(posedge aclk) begin
    if (all_rst) begin
      out_a_n_r <= 1'b1;
      out_b_n_r <= 1'b1;
      rts_n_r <= 1'b1;
      tick_r <= 1'b0;
      host_data_r <= 8'h00;
    end else begin
      out_a_n_r <= !(mcr_r.out_a && !mcr_r.loop);
      out_b_n_r <= !(mcr_r.out_b && !mcr_r.loop);
      rts_n_r <= !mcr_r.rts || mcr_r.loop || (mcr_r.auto_rts && rx_threshold_hit);
      tick_r <= rck_edge;
      if (pin_rd_rise) host_data_r <= pin_word;
    end
  end

  // write channel: address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      bvalid_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 8'h00;
      w_strb_r <= 1'b0;
      bresp_r <= `UMX_RESP_OKAY;
    end else begin
      if (aw_take) aw_addr_r <= s_axi_awaddr;
      if (w_take) w_data_r <= s_axi_wdata[7:0];
      if (w_take) w_strb_r <= s_axi_wstrb[0];
      aw_hold_r <= (aw_hold_r || aw_take) && !wr_go;
      w_hold_r <= (w_hold_r || w_take) && !wr_go;
      if (wr_go) bresp_r <= wr_hit ? `UMX_RESP_OKAY : `UMX_RESP_SLVERR;
      bvalid_r <= wr_go || (bvalid_r && !s_axi_bready);
    end
  end

  // read channel: one outstanding read, answered the cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `UMX_RESP_OKAY;
    end else begin
      if (ar_go) rdata_r <= rd_hit ? {24'h000000, axi_word} : 32'h0000_0000;
      if (ar_go) rresp_r <= rd_hit ? `UMX_RESP_OKAY : `UMX_RESP_SLVERR;
      rvalid_r <= ar_go || (rvalid_r && !s_axi_rready);
    end
  end

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  assign user_output_a_n = out_a_n_r;
  assign user_output_b_n = out_b_n_r;
  assign request_to_send_n = rts_n_r;
  assign loop_mode = mcr_r.loop;
  assign rx_sample_tick = tick_r;
  // bus driver enabled for the whole strobe, data latched at its start
  assign host_data_oe = pin_rd_act;
  assign host_data_o = host_data_r;
  assign irq = |(isr_r & imr_r);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence pin_read_start;
    pin_rd_act && !pin_rd_d && pin_idx_ok && (pin_idx == `UMX_IDX_MSR) && !mr_s2;
  endsequence

  sequence ring_rise_seen;
    ring_s2 && !ring_d;
  endsequence

  user_out_on_a: assert property (
    mcr_r.out_a && mcr_r.out_b && !mcr_r.loop && !mr_s2 |=> !user_output_a_n && !user_output_b_n
  ) else $error("user output not driven low");

  user_out_off_a: assert property (
    (!mcr_r.out_a || mcr_r.loop || mr_s2) |=> user_output_a_n
  ) else $error("user output a not high");

  user_outb_off_a: assert property (
    (!mcr_r.out_b || mcr_r.loop || mr_s2) |=> user_output_b_n
  ) else $error("user output b not high");

  pin_read_data_a: assert property (
    pin_read_start |=> (host_data_o[`UMX_MSR_RING_BIT] == $past(ring_s2))
    && (host_data_o[`UMX_MSR_FLAG_BIT] == $past(ring_flag_r))
  ) else $error("pin read returned wrong ring level");

  pin_unselected_a: assert property (
    !pin_sel |-> !host_data_oe
  ) else $error("data bus driven while unselected");

  ring_level_a: assert property (
    axi_msr_rd |=> s_axi_rvalid && (s_axi_rdata[`UMX_MSR_RING_BIT] == $past(ring_s2))
  ) else $error("ring level wrong in modem status");

  ring_flag_set_a: assert property (
    ring_rise_seen and !mr_s2 |=> ring_flag_r
  ) else $error("ring flag not set on rising edge");

  ring_flag_hold_a: assert property (
    ring_flag_r && !msr_read && !mr_s2 |=> ring_flag_r
  ) else $error("ring flag lost before status read");

  ring_flag_clr_a: assert property (
    msr_read && !ring_edge |=> !ring_flag_r
  ) else $error("ring flag survived status read");

  ring_irq_a: assert property (
    ring_rise_seen and (imr_r[`UMX_INT_RING_BIT] && !wr_imr && !mr_s2) |=> irq
  ) else $error("enabled ring edge raised no interrupt");

  rts_active_a: assert property (
    mcr_r.rts && !mcr_r.loop && !mcr_r.auto_rts && !mr_s2 |=> !request_to_send_n
  ) else $error("request to send not active");

  rts_inactive_a: assert property (
    (!mcr_r.rts || mcr_r.loop || mr_s2) |=> request_to_send_n
  ) else $error("request to send not inactive");

  auto_rts_a: assert property (
    mcr_r.auto_rts && rx_threshold_hit |=> request_to_send_n
  ) else $error("threshold did not drop request to send");

  master_reset_a: assert property (
    mr_s2 |=> (mcr_r == `UMX_MCR_RST) && (isr_r == `UMX_ISR_RST) && !ring_flag_r
  ) else $error("master reset left registers set");

  ring_once_a: assert property (
    ring_edge |=> !ring_edge
  ) else $error("ring edge counted twice");

  rx_tick_a: assert property (
    rck_s2 && !rck_d && !mr_s2 |=> rx_sample_tick ##1 !rx_sample_tick
  ) else $error("receive tick not one cycle");

endmodule

// ---- verification/umx_modem_model.sv ----
// modem side model: ring indicate line and 16x receive clock
`timescale 1ns/10ps
module umx_modem_model (
  input wire logic aclk,
  input wire logic ring_cmd,
  input wire logic rclk_en,
  output logic ring_indicate,
  output logic receiver_clock,
  output int rclk_edges
);
  int ph;
  initial begin
    ring_indicate = 1'b0;
    receiver_clock = 1'b0;
    rclk_edges = 0;
    ph = 0;
  end
  always @(posedge aclk) begin
    ring_indicate <= ring_cmd;
    // clock stands still when idle; half period of 4 keeps it below aclk/4
    if (rclk_en) begin
      ph <= ph + 1;
      if (ph % 4 == 3) begin
        receiver_clock <= ~receiver_clock;
        if (!receiver_clock) begin
          rclk_edges <= rclk_edges + 1;
        end
      end
    end
  end
endmodule

// ---- verification/uart_modem_pins_and_read_strobe_tb.sv ----
// self-checking bench for the modem pin block
`timescale 1ns/10ps
`include "umx_map.svh"
module uart_modem_pins_and_read_strobe_tb import umx_pkg::*; ;
  localparam umx_pbus_t IDLE = 8'h30;
  logic aclk, aresetn, mr, ring_cmd, rclk_en, thr, rclk_pin, ring_pin;
  logic hoe, oa_n, ob_n, rts_n, loop_m, tick, irq;
  logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [7:0] hdo, awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  int rclk_edges, ticks, err_total, tests_run;
  umx_pbus_t hb;
  logic [7:0] mv [6] = '{8'h02, 8'h04, 8'h08, 8'h0e, 8'h1e, 8'h00};
  logic [3:0] pv [6] = '{4'h3, 4'h6, 4'h5, 4'h0, 4'hf, 4'h7};

  umx_top uut (.aclk(aclk), .aresetn(aresetn), .master_reset_input(mr),
    .ring_indicate(ring_pin), .receiver_clock(rclk_pin), .host_bus(hb),
    .rx_threshold_hit(thr), .host_data_o(hdo), .host_data_oe(hoe),
    .user_output_a_n(oa_n), .user_output_b_n(ob_n), .request_to_send_n(rts_n),
    .loop_mode(loop_m), .rx_sample_tick(tick), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));

  umx_modem_model modem (.aclk(aclk), .ring_cmd(ring_cmd), .rclk_en(rclk_en),
    .ring_indicate(ring_pin), .receiver_clock(rclk_pin), .rclk_edges(rclk_edges));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (tick === 1'b1) begin
      ticks <= ticks + 1;
    end
  end

  task wrap_up;
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // address and data offered together, each dropped once its ready is seen
  task axw(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    rs = bresp;
    br <= 1'b0;
    @(posedge aclk);
  endtask

  task axr(input logic [7:0] a);
    araddr <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rd = rdata;
    rs = rresp;
    rr <= 1'b0;
    @(posedge aclk);
  endtask

  // parallel read with one strobe; the other is held inactive
  task pread(input logic [2:0] a, input logic hi, input logic [7:0] exp);
    hb <= {3'b110, hi, hi, a};
    do begin
      @(posedge aclk);
    end while (hoe !== 1'b1);
    cyc(2);
    chk({24'h0, hdo}, {24'h0, exp});
    hb <= IDLE;
    cyc(5);
    chk({31'h0, hoe}, 32'h0);
  endtask

  initial begin
    #1_000_000;
    err_total++;
    wrap_up();
  end

  initial begin
    {aresetn, mr, ring_cmd, rclk_en, thr, awv, wv, br, arv, rr} = '0;
    {awaddr, araddr, wdata, ticks, err_total, tests_run} = '0;
    hb = IDLE;
    cyc(2);
    aresetn <= 1'b1;
    cyc(3);
    chk({oa_n, ob_n, rts_n, irq, hoe}, 5'b11100);
    for (int i = 0; i < 6; i++) begin
      axw(`UMX_OFF_MCR, {24'h0, mv[i]});
      cyc(2);
      chk({loop_m, rts_n, ob_n, oa_n}, pv[i]);
      axr(`UMX_OFF_MCR);
      chk(rd, {24'h0, mv[i]});
    end
    axw(`UMX_OFF_MCR, 32'h22);
    cyc(2);
    chk(rts_n, 1'b0);
    thr <= 1'b1;
    cyc(2);
    chk(rts_n, 1'b1);
    thr <= 1'b0;
    cyc(2);
    chk(rts_n, 1'b0);
    pread(3'h0, 1'b0, 8'h22);
    pread(3'h0, 1'b1, 8'h22);
    hb <= {3'b010, 1'b0, 1'b1, 3'h0};
    cyc(5);
    chk(hoe, 1'b0);
    hb <= IDLE;
    axw(`UMX_OFF_IMR, 32'h1);
    chk({30'h0, rs}, {30'h0, `UMX_RESP_OKAY});
    ring_cmd <= 1'b1;
    cyc(5);
    chk(irq, 1'b1);
    axr(`UMX_OFF_MSR);
    chk(rd, 32'h44);
    chk({30'h0, rs}, {30'h0, `UMX_RESP_OKAY});
    axr(`UMX_OFF_MSR);
    chk(rd, 32'h40);
    axw(`UMX_OFF_ISR, 32'h1);
    cyc(1);
    chk(irq, 1'b0);
    ring_cmd <= 1'b0;
    cyc(4);
    pread(3'h1, 1'b0, 8'h00);
    axw(`UMX_OFF_IMR, 32'h0);
    ring_cmd <= 1'b1;
    cyc(5);
    chk(irq, 1'b0);
    pread(3'h1, 1'b1, 8'h44);
    axr(`UMX_OFF_ISR);
    chk(rd, 32'h1);
    axr(8'h10);
    chk({30'h0, rs}, {30'h0, `UMX_RESP_SLVERR});
    chk(rd, 32'h0);
    axw(8'h14, 32'h1);
    chk({30'h0, rs}, {30'h0, `UMX_RESP_SLVERR});
    rclk_en <= 1'b1;
    cyc(80);
    rclk_en <= 1'b0;
    cyc(6);
    chk(ticks, rclk_edges);
    axw(`UMX_OFF_MCR, 32'h0e);
    cyc(2);
    mr <= 1'b1;
    cyc(5);
    chk({rts_n, ob_n, oa_n}, 3'b111);
    mr <= 1'b0;
    cyc(4);
    axr(`UMX_OFF_MCR);
    chk(rd, 32'h0);
    wrap_up();
  end
endmodule
